// File: common/hsc_pkg.sv
// shared constants and types of the half-duplex suppression control block
package hsc_pkg;

    // clock and time base
    localparam int unsigned CLK_HZ            = 100_000_000;
    localparam int unsigned TICK_US           = 250;
    localparam int unsigned TICK_CYCLES_DEF   = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned TICKS_PER_S       = 1_000_000 / TICK_US;

    // register addresses and fixed low nibbles
    localparam logic [3:0]  ADDR_HD_DETECT    = 4'h2;
    localparam logic [3:0]  ADDR_SUPPRESS     = 4'h3;
    localparam logic [3:0]  ADDR_STATUS       = 4'h8;
    localparam logic [3:0]  HD_DETECT_TAG     = 4'h4;
    localparam logic [3:0]  SUPPRESS_TAG      = 4'h6;
    localparam logic [15:0] HD_DETECT_RESET   = {12'h000, HD_DETECT_TAG};
    localparam logic [15:0] SUPPRESS_RESET    = {12'h000, SUPPRESS_TAG};

    // half_duplex_detect_control fields
    localparam int RX_HD_THR_LSB    = 14;
    localparam int RX_SUPP_THR_LSB  = 12;
    localparam int NOISE_RAMP_LSB   = 10;
    localparam int HOLDOVER_LSB     = 8;
    localparam int HOLD_HOWL_BIT    = 7;
    localparam int TX_DT_DECAY_BIT  = 6;
    localparam int RX_DT_DECAY_BIT  = 5;
    localparam int IDLE_TX_BIT      = 4;

    // suppression_control fields
    localparam int TX_SUPP_ATT_LSB  = 14;
    localparam int PATH_SENS_BIT    = 13;
    localparam int TX_DT_ATT_LSB    = 10;
    localparam int RX_DT_ATT_LSB    = 8;
    localparam int TX_SUPP_THR_LSB  = 6;
    localparam int TX_SUPP_BIAS_LSB = 4;

    // level figures in dB
    localparam logic [7:0] DB_3  = 8'h03;
    localparam logic [7:0] DB_6  = 8'h06;
    localparam logic [7:0] DB_9  = 8'h09;
    localparam logic [7:0] DB_12 = 8'h0C;
    localparam logic [7:0] DB_15 = 8'h0F;
    localparam logic [7:0] DB_18 = 8'h12;
    localparam logic [7:0] DB_21 = 8'h15;
    localparam logic [7:0] DB_24 = 8'h18;
    localparam logic [7:0] RX_SUPP_ATTEN_DB = DB_24;

    // holdover delays
    localparam int unsigned HOLDOVER_A_MS = 200;
    localparam int unsigned HOLDOVER_B_MS = 100;
    localparam int unsigned HOLDOVER_C_MS = 150;
    localparam logic [9:0]  HOLDOVER_A_TICKS = 10'(HOLDOVER_A_MS * 1000 / TICK_US);
    localparam logic [9:0]  HOLDOVER_B_TICKS = 10'(HOLDOVER_B_MS * 1000 / TICK_US);
    localparam logic [9:0]  HOLDOVER_C_TICKS = 10'(HOLDOVER_C_MS * 1000 / TICK_US);

    // double-talk ramps, level moves in sixteenths of the target
    localparam int unsigned DT_STEPS          = 16;
    localparam logic [4:0]  DT_FULL           = 5'(DT_STEPS);
    localparam int unsigned DT_ATTACK_MS      = 40;
    localparam int unsigned DT_DECAY_SLOW_MS  = 1000;
    localparam int unsigned DT_DECAY_NORM_MS  = 100;
    localparam logic [7:0]  DT_ATTACK_TICKS   = 8'(DT_ATTACK_MS * 1000 / TICK_US / DT_STEPS);
    localparam logic [7:0]  DT_SLOW_TICKS     = 8'(DT_DECAY_SLOW_MS * 1000 / TICK_US / DT_STEPS);
    localparam logic [7:0]  DT_NORM_TICKS     = 8'(DT_DECAY_NORM_MS * 1000 / TICK_US / DT_STEPS);

    // noise estimator: 8.4 dB format, base rate 3 dB/s
    localparam int unsigned NOISE_FRAC_STEPS  = 16;
    localparam int unsigned NOISE_BASE_DB_S   = 3;
    localparam int unsigned NOISE_STEP_CYCLES_DEF = CLK_HZ / (NOISE_BASE_DB_S * NOISE_FRAC_STEPS);

    // register bus request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } hsc_reg_req_t;

    // attenuations handed to the audio path, quarter-dB for double-talk
    typedef struct packed {
        logic [7:0] rx_supp_db;
        logic [7:0] tx_supp_db;
        logic [7:0] tx_dt_qdb;
        logic [7:0] rx_dt_qdb;
    } hsc_atten_t;

    typedef enum logic [1:0] {HSC_IDLE, HSC_TX, HSC_RX} hsc_hd_state_t;

endpackage

// File: hdl/hsc_ctrl.sv
// half-duplex switching and echo suppression control with its two registers
`timescale 1ns/1ps

module hsc_dt_ramp
    import hsc_pkg::*;
(
    // clock and reset
    input  wire logic       clock_in,
    input  wire logic       reset_in,
    // control
    input  wire logic       tick_in,
    input  wire logic       active_in,
    input  wire logic       slow_decay_in,
    input  wire logic [4:0] target_db_in,
    // result in quarter dB
    output logic [7:0]      atten_out
);
    logic [4:0] frac_q;
    logic [7:0] step_cnt_q;
    logic [7:0] step_len;
    logic       moving;
    logic [9:0] product;

    // attack uses a fixed pace; decay pace comes from the select bit
    always_comb begin
        if (active_in) begin
            step_len = DT_ATTACK_TICKS;
        end else if (slow_decay_in) begin
            step_len = DT_SLOW_TICKS;
        end else begin
            step_len = DT_NORM_TICKS;
        end
        moving  = active_in ? (frac_q != DT_FULL) : (frac_q != 5'h00);
        product = {5'h00, target_db_in} * {5'h00, frac_q};
    end

    // one sixteenth of the target per step, so timing is the same for every target
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            frac_q     <= 5'h00;
            step_cnt_q <= 8'h00;
        end else if (!moving) begin
            step_cnt_q <= 8'h00;
        end else if (tick_in) begin
            if (step_cnt_q + 8'h01 >= step_len) begin
                step_cnt_q <= 8'h00;
                frac_q     <= active_in ? frac_q + 5'h01 : frac_q - 5'h01;
            end else begin
                step_cnt_q <= step_cnt_q + 8'h01;
            end
        end
    end

    // scaled output, target times sixteenths gives quarter dB
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            atten_out <= 8'h00;
        end else begin
            atten_out <= product[9:2];
        end
    end
endmodule

module hsc_ctrl
    import hsc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES       = TICK_CYCLES_DEF,
    parameter int unsigned NOISE_STEP_CYCLES = NOISE_STEP_CYCLES_DEF
)(
    // clock and reset
    input  wire logic          clock_in,
    input  wire logic          reset_in,
    // register port
    input  wire hsc_reg_req_t  reg_req_in,
    output logic [15:0]        rd_data_out,
    // measurements from the audio path
    input  wire logic [7:0]    rx_power_db_in,
    input  wire logic [7:0]    tx_power_db_in,
    input  wire logic          tx_speech_in,
    input  wire logic          double_talk_in,
    input  wire logic          howl_event_in,
    input  wire logic          path_change_in,
    input  wire logic          full_duplex_ready_in,
    // control results
    output hsc_hd_state_t      hd_state_out,
    output logic               full_duplex_out,
    output logic               retrain_out,
    output logic               rx_speech_out,
    output logic [11:0]        noise_floor_out,
    output hsc_atten_t         atten_out
);
    logic [15:0]   hd_ctrl_q;
    logic [15:0]   supp_ctrl_q;
    logic [15:0]   rd_data_d;
    logic [14:0]   tick_cnt_q;
    logic          tick;
    logic [21:0]   noise_cnt_q;
    logic          noise_step;
    logic [11:0]   noise_q;
    logic [11:0]   rx_pow16;
    logic [11:0]   noise_inc;
    logic [12:0]   noise_sum;
    logic [7:0]    rx_hd_thr_db;
    logic [7:0]    rx_supp_thr_db;
    logic [9:0]    holdover_ticks;
    logic [7:0]    tx_supp_att_db;
    logic [7:0]    tx_supp_thr_db;
    logic [7:0]    tx_supp_bias_db;
    logic          rx_speech;
    logic          rx_far_active;
    logic          tx_supp_engaged;
    hsc_hd_state_t state_q;
    logic [9:0]    hold_cnt_q;
    logic          parked_q;
    logic          owner_active;
    logic          full_q;
    logic          howl_hold_q;
    logic          retrain_q;
    logic          drop_event;
    logic          dt_active;
    logic [7:0]    tx_dt_qdb;
    logic [7:0]    rx_dt_qdb;
    logic [7:0]    rx_supp_db_q;
    logic [7:0]    tx_supp_db_q;

    // register writes; low nibble is a fixed tag
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            hd_ctrl_q   <= HD_DETECT_RESET;
            supp_ctrl_q <= SUPPRESS_RESET;
        end else if (reg_req_in.wr) begin
            if (reg_req_in.addr == ADDR_HD_DETECT) begin
                hd_ctrl_q <= {reg_req_in.wdata[15:4], HD_DETECT_TAG};
            end
            if (reg_req_in.addr == ADDR_SUPPRESS) begin
                supp_ctrl_q <= {reg_req_in.wdata[15:4], SUPPRESS_TAG};
            end
        end
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        case (reg_req_in.addr)
            ADDR_HD_DETECT: rd_data_d = hd_ctrl_q;
            ADDR_SUPPRESS:  rd_data_d = supp_ctrl_q;
            ADDR_STATUS:    rd_data_d = {state_q, full_q, howl_hold_q, rx_speech, tx_supp_engaged,
                                         rx_far_active, 1'b0, noise_q[11:4]};
            default:        rd_data_d = 16'h0000;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rd_data_out <= 16'h0000;
        end else if (reg_req_in.rd) begin
            rd_data_out <= rd_data_d;
        end else begin
            rd_data_out <= 16'h0000;
        end
    end

    // field decode; reserved codes fall back to the reset meaning
    always_comb begin
        case (hd_ctrl_q[RX_HD_THR_LSB +: 2])
            2'b01:   rx_hd_thr_db = DB_9;
            2'b10:   rx_hd_thr_db = DB_12;
            default: rx_hd_thr_db = DB_6;
        endcase
        case (hd_ctrl_q[RX_SUPP_THR_LSB +: 2])
            2'b01:   rx_supp_thr_db = DB_9;
            2'b10:   rx_supp_thr_db = DB_12;
            default: rx_supp_thr_db = DB_6;
        endcase
        case (hd_ctrl_q[HOLDOVER_LSB +: 2])
            2'b01:   holdover_ticks = HOLDOVER_B_TICKS;
            2'b10:   holdover_ticks = HOLDOVER_C_TICKS;
            default: holdover_ticks = HOLDOVER_A_TICKS;
        endcase
        case (hd_ctrl_q[NOISE_RAMP_LSB +: 2])
            2'b01:   noise_inc = 12'h002;
            2'b10:   noise_inc = 12'h004;
            default: noise_inc = 12'h001;
        endcase
        case (supp_ctrl_q[TX_SUPP_ATT_LSB +: 2])
            2'b01:   tx_supp_att_db = DB_12;
            2'b10:   tx_supp_att_db = DB_24;
            default: tx_supp_att_db = DB_18;
        endcase
        case (supp_ctrl_q[TX_SUPP_THR_LSB +: 2])
            2'b01:   tx_supp_thr_db = DB_12;
            2'b10:   tx_supp_thr_db = DB_9;
            2'b11:   tx_supp_thr_db = DB_18;
            default: tx_supp_thr_db = DB_15;
        endcase
        case (supp_ctrl_q[TX_SUPP_BIAS_LSB +: 2])
            2'b01:   tx_supp_bias_db = DB_15;
            2'b10:   tx_supp_bias_db = DB_21;
            default: tx_supp_bias_db = DB_18;
        endcase
    end

    // quarter-millisecond tick for holdover and ramps
    always_ff @(posedge clock_in) begin
        if (reset_in || tick) begin
            tick_cnt_q <= 15'h0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 15'h0001;
        end
    end
    assign tick = (tick_cnt_q == 15'(TICK_CYCLES - 1));

    // noise pacing; faster rates take bigger steps
    always_ff @(posedge clock_in) begin
        if (reset_in || noise_step) begin
            noise_cnt_q <= 22'h000000;
        end else begin
            noise_cnt_q <= noise_cnt_q + 22'h000001;
        end
    end
    assign noise_step = (noise_cnt_q == 22'(NOISE_STEP_CYCLES - 1));

    assign rx_pow16  = {rx_power_db_in, 4'h0};
    assign noise_sum = {1'b0, noise_q} + {1'b0, noise_inc};

    // rx noise floor: drops at once, climbs at ramp rate
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            noise_q <= 12'h000;
        end else if (rx_pow16 < noise_q) begin
            noise_q <= rx_pow16;
        end else if (noise_step) begin
            if (noise_sum >= {1'b0, rx_pow16}) begin
                noise_q <= rx_pow16;
            end else begin
                noise_q <= noise_sum[11:0];
            end
        end
    end

    // speech detectors against the floor, 13 bits so nothing wraps
    always_comb begin
        rx_speech     = {1'b0, rx_pow16} > ({1'b0, noise_q} + {1'b0, rx_hd_thr_db, 4'h0});
        rx_far_active = {1'b0, rx_pow16} > ({1'b0, noise_q} + {1'b0, rx_supp_thr_db, 4'h0});
        // near end breaks in when it beats the far end by more than bias minus echo-loss need
        tx_supp_engaged = rx_speech &&
            (({1'b0, rx_power_db_in} + {1'b0, tx_supp_bias_db}) >=
             ({1'b0, tx_power_db_in} + {1'b0, tx_supp_thr_db}));
    end

    // howl latch: cleared by reset or by software clearing the hold flag
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            howl_hold_q <= 1'b0;
        end else if (!hd_ctrl_q[HOLD_HOWL_BIT]) begin
            howl_hold_q <= 1'b0;
        end else if (howl_event_in) begin
            howl_hold_q <= 1'b1;
        end
    end

    // low sensitivity ignores path changes so the canceller adapts in full duplex
    assign drop_event = howl_event_in ||
                        (path_change_in && !supp_ctrl_q[PATH_SENS_BIT]);

    // duplex mode: drop on events, return once trained
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            full_q    <= 1'b0;
            retrain_q <= 1'b0;
        end else begin
            retrain_q <= drop_event && full_q;
            if (drop_event) begin
                full_q <= 1'b0;
            end else if (full_duplex_ready_in && !howl_hold_q) begin
                full_q <= 1'b1;
            end
        end
    end

    assign owner_active = (state_q == HSC_RX) ? rx_speech : tx_speech_in;

    // half-duplex engine; owner keeps the channel through the holdover
    always_ff @(posedge clock_in) begin
        if (reset_in || full_q) begin
            state_q    <= HSC_IDLE;
            hold_cnt_q <= 10'h000;
            parked_q   <= 1'b0;
        end else begin
            case (state_q)
                HSC_IDLE: begin
                    hold_cnt_q <= 10'h000;
                    if (rx_speech) begin
                        state_q  <= HSC_RX;
                        parked_q <= 1'b0;
                    end else if (tx_speech_in) begin
                        state_q  <= HSC_TX;
                        parked_q <= 1'b0;
                    end else if (hd_ctrl_q[IDLE_TX_BIT]) begin
                        state_q  <= HSC_TX;
                        parked_q <= 1'b1;
                    end
                end
                HSC_TX, HSC_RX: begin
                    if (parked_q && state_q == HSC_TX && !tx_speech_in) begin
                        // parked in transmit without talk: far end may take over freely
                        hold_cnt_q <= 10'h000;
                        if (rx_speech) begin
                            state_q  <= HSC_RX;
                            parked_q <= 1'b0;
                        end
                    end else if (owner_active) begin
                        hold_cnt_q <= 10'h000;
                        parked_q   <= 1'b0;
                    end else if (hold_cnt_q >= holdover_ticks) begin
                        state_q    <= HSC_IDLE;
                        hold_cnt_q <= 10'h000;
                    end else if (tick) begin
                        hold_cnt_q <= hold_cnt_q + 10'h001;
                    end
                end
                default: begin
                    state_q    <= HSC_IDLE;
                    hold_cnt_q <= 10'h000;
                    parked_q   <= 1'b0;
                end
            endcase
        end
    end

    // double talk only matters while both directions are open
    assign dt_active = full_q && double_talk_in;

    hsc_dt_ramp u_tx_dt (
        .clock_in      (clock_in),
        .reset_in      (reset_in),
        .tick_in       (tick),
        .active_in     (dt_active),
        .slow_decay_in (!hd_ctrl_q[TX_DT_DECAY_BIT]),
        .target_db_in  (5'(supp_ctrl_q[TX_DT_ATT_LSB +: 3]) * 5'h03),
        .atten_out     (tx_dt_qdb)
    );

    hsc_dt_ramp u_rx_dt (
        .clock_in      (clock_in),
        .reset_in      (reset_in),
        .tick_in       (tick),
        .active_in     (dt_active),
        .slow_decay_in (!hd_ctrl_q[RX_DT_DECAY_BIT]),
        .target_db_in  (5'(supp_ctrl_q[RX_DT_ATT_LSB +: 2]) * 5'h03),
        .atten_out     (rx_dt_qdb)
    );

    // suppressor attenuations; rx depth is fixed whatever its threshold
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rx_supp_db_q <= 8'h00;
            tx_supp_db_q <= 8'h00;
        end else begin
            rx_supp_db_q <= rx_far_active ? 8'h00 : RX_SUPP_ATTEN_DB;
            tx_supp_db_q <= tx_supp_engaged ? tx_supp_att_db : 8'h00;
        end
    end

    // outputs
    assign hd_state_out         = state_q;
    assign full_duplex_out      = full_q;
    assign retrain_out          = retrain_q;
    assign rx_speech_out        = rx_speech;
    assign noise_floor_out      = noise_q;
    assign atten_out.rx_supp_db = rx_supp_db_q;
    assign atten_out.tx_supp_db = tx_supp_db_q;
    assign atten_out.tx_dt_qdb  = tx_dt_qdb;
    assign atten_out.rx_dt_qdb  = rx_dt_qdb;
endmodule

// File: sim/hsc_ctrl_checker.sv
// concurrent checks on the suppression control ports
`timescale 1ns/1ps
module hsc_ctrl_checker
    import hsc_pkg::*;
(
    // clock and reset
    input wire logic          clock_in,
    input wire logic          reset_in,
    // register port
    input wire hsc_reg_req_t  reg_req_in,
    // audio path measurements
    input wire logic [7:0]    rx_power_db_in,
    input wire logic          howl_event_in,
    input wire logic          path_change_in,
    input wire logic          full_duplex_ready_in,
    // results
    input wire hsc_hd_state_t hd_state_out,
    input wire logic          full_duplex_out,
    input wire logic          retrain_out,
    input wire logic          rx_speech_out,
    input wire logic [11:0]   noise_floor_out,
    input wire hsc_atten_t    atten_out
);
    logic [15:0] hd_q;
    logic [15:0] sup_q;
    logic [12:0] p16;
    logic [12:0] rh_lim;
    logic [12:0] rs_lim;
    logic        rst_seen_q;

    // threshold in sixteenths of a dB
    function automatic logic [12:0] thr16(input logic [1:0] c);
        return (c == 2'h1) ? 13'h090 : ((c == 2'h2) ? 13'h0C0 : 13'h060);
    endfunction

    // shadow of both registers
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            hd_q  <= HD_DETECT_RESET;
            sup_q <= SUPPRESS_RESET;
        end else if (reg_req_in.wr && reg_req_in.addr == ADDR_HD_DETECT) begin
            hd_q <= reg_req_in.wdata;
        end else if (reg_req_in.wr && reg_req_in.addr == ADDR_SUPPRESS) begin
            sup_q <= reg_req_in.wdata;
        end
    end

    // 13 bits so sums cannot wrap
    assign p16    = {1'b0, rx_power_db_in, 4'h0};
    assign rh_lim = {1'b0, noise_floor_out} + thr16(hd_q[15:14]);
    assign rs_lim = {1'b0, noise_floor_out} + thr16(hd_q[13:12]);

    // outputs hold reset values one edge past release
    always_ff @(posedge clock_in) begin
        rst_seen_q <= reset_in;
    end

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (reset_in || rst_seen_q);

    chk_speech_detect: assert property (rx_speech_out == (p16 > rh_lim))
        else $error("rx speech flag wrong");
    chk_rx_supp_open: assert property (p16 > rs_lim |=> atten_out.rx_supp_db == 8'h00)
        else $error("rx suppression not released");
    chk_rx_supp_shut: assert property (p16 <= rs_lim |=> atten_out.rx_supp_db == RX_SUPP_ATTEN_DB)
        else $error("rx suppression not inserted");
    chk_noise_drop: assert property (p16 < {1'b0, noise_floor_out} |=> noise_floor_out == $past(p16[11:0]))
        else $error("noise floor did not follow a drop");
    chk_howl_drop: assert property (howl_event_in |=> !full_duplex_out)
        else $error("howl did not drop to half duplex");
    chk_retrain_pulse: assert property (howl_event_in && full_duplex_out |=> retrain_out ##1 !retrain_out)
        else $error("retrain pulse wrong");
    chk_path_high: assert property (path_change_in && !sup_q[13] |=> !full_duplex_out)
        else $error("path change kept full duplex");
    chk_path_low: assert property (path_change_in && sup_q[13] && !howl_event_in && full_duplex_out
        && full_duplex_ready_in |=> full_duplex_out) else $error("path change at low sensitivity dropped");
    chk_owner_holds: assert property (hd_state_out == HSC_RX && rx_speech_out && $past(rx_speech_out)
        && !full_duplex_out && !full_duplex_ready_in |=> hd_state_out == HSC_RX) else $error("rx owner lost");

    cov_retrain: cover property (retrain_out);
    cov_tx_owner: cover property (hd_state_out == HSC_TX);
    cov_dt_full: cover property (atten_out.tx_dt_qdb == 8'h54);
endmodule

bind hsc_ctrl hsc_ctrl_checker u_hsc_chk (
    .clock_in(clock_in), .reset_in(reset_in), .reg_req_in(reg_req_in), .rx_power_db_in(rx_power_db_in),
    .howl_event_in(howl_event_in), .path_change_in(path_change_in), .full_duplex_ready_in(full_duplex_ready_in),
    .hd_state_out(hd_state_out), .full_duplex_out(full_duplex_out), .retrain_out(retrain_out),
    .rx_speech_out(rx_speech_out), .noise_floor_out(noise_floor_out), .atten_out(atten_out));

// File: sim/hsc_ctrl_tb_top.sv
// self-checking bench of the suppression control block
`timescale 1ns/1ps
module hsc_ctrl_tb_top
    import hsc_pkg::*;
;
    logic          clock_in = 1'b0;
    logic          reset_in = 1'b1;
    hsc_reg_req_t  req      = '0;
    logic [7:0]    rxp      = 8'h00;
    logic [7:0]    txp      = 8'h00;
    logic          txs      = 1'b0;
    logic          dtk      = 1'b0;
    logic          howl     = 1'b0;
    logic          pch      = 1'b0;
    logic          rdy      = 1'b0;
    logic [15:0]   rd_data;
    hsc_hd_state_t st;
    logic          full;
    hsc_atten_t    att;
    logic [15:0]   rd_q[$];
    logic          rd_pend  = 1'b0;
    logic [31:0]   seed     = 32'hDF82FFA4;
    logic [15:0]   v;
    int            n;
    int            n_errors = 0;
    int            checked  = 0;
    logic [7:0]    att_tab[3]  = '{DB_18, DB_12, DB_24};
    logic [7:0]    thd_tab[4]  = '{DB_15, DB_12, DB_9, DB_18};
    logic [7:0]    bias_tab[3] = '{DB_18, DB_15, DB_21};

    // short tick and noise step keep ramps brief
    hsc_ctrl #(.TICK_CYCLES(4), .NOISE_STEP_CYCLES(8)) dut (
        .clock_in(clock_in), .reset_in(reset_in), .reg_req_in(req), .rd_data_out(rd_data),
        .rx_power_db_in(rxp), .tx_power_db_in(txp), .tx_speech_in(txs), .double_talk_in(dtk),
        .howl_event_in(howl), .path_change_in(pch), .full_duplex_ready_in(rdy), .hd_state_out(st),
        .full_duplex_out(full), .retrain_out(), .rx_speech_out(), .noise_floor_out(), .atten_out(att));

    always #5 clock_in = ~clock_in;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // reserved codes made legal
    function automatic logic [15:0] fix(input logic [15:0] w, input logic [7:0] m);
        for (int i = 0; i < 8; i++) begin
            if (m[i] && w[2*i+:2] == 2'h3) begin
                w[2*i+1] = 1'b0;
            end
        end
        return w;
    endfunction

    task automatic give_verdict;
        if (n_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    // strobes stay up until rel drops them
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        req <= {1'b1, 1'b0, a, d};
        @(posedge clock_in);
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        req <= {1'b0, 1'b1, a, 16'h0000};
        rd_q.push_back(e);
        @(posedge clock_in);
    endtask

    task automatic rel;
        req <= '0;
        @(posedge clock_in);
    endtask

    // bounded wait for st to leave s
    task automatic leave(input hsc_hd_state_t s, output int c);
        c = 0;
        @(negedge clock_in);
        while (st === s && c < 2000) begin
            @(negedge clock_in);
            c++;
        end
        if (c >= 2000) begin
            cmp("leave_bound", 16'h0000, 16'h0001);
            give_verdict();
        end
    endtask

    // read data checked the cycle after rd
    always @(posedge clock_in) begin
        if (rd_pend) begin
            cmp("rd_data", rd_q.pop_front(), rd_data);
        end
        rd_pend <= req.rd;
    end

    initial begin
        repeat (16) @(posedge clock_in);
        reset_in <= 1'b0;
        rd(ADDR_HD_DETECT, HD_DETECT_RESET);
        rd(ADDR_SUPPRESS, SUPPRESS_RESET);
        wr(4'h5, 16'hFFFF);
        rd(4'h5, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            v = fix(seed[15:0], 8'hF0);
            wr(ADDR_HD_DETECT, v);
            rd(ADDR_HD_DETECT, {v[15:4], HD_DETECT_TAG});
            seed = lfsr(seed);
            v = fix(seed[31:16], 8'h84);
            wr(ADDR_SUPPRESS, v);
            rd(ADDR_SUPPRESS, {v[15:4], SUPPRESS_TAG});
        end
        // each tx suppression code at and above the engage edge
        wr(ADDR_HD_DETECT, 16'h0100);
        rxp <= 8'h28;
        for (int k = 0; k < 24; k++) begin
            txp <= 8'(40 + bias_tab[k % 3] - thd_tab[k / 3 % 4] + k / 12);
            wr(ADDR_SUPPRESS, {2'(k % 3), 6'h00, 2'(k / 3 % 4), 2'(k % 3), 4'h0});
            rel();
            repeat (2) @(posedge clock_in);
            @(negedge clock_in);
            cmp("tx_supp_db", 16'(k < 12 ? att_tab[k % 3] : 8'h00), 16'(att.tx_supp_db));
            @(posedge clock_in);
        end
        // rx owner silent, tx waits out holdover
        rxp <= 8'h00;
        txs <= 1'b1;
        leave(HSC_RX, n);
        cmp("holdover_ok", 16'h0001, 16'(n inside {[1590:1620]}));
        cmp("state_idle", 16'(HSC_IDLE), 16'(st));
        @(posedge clock_in);
        txs <= 1'b0;
        wr(ADDR_HD_DETECT, 16'h0110);
        rel();
        leave(HSC_TX, n);
        cmp("idle_first", 16'(HSC_IDLE), 16'(st));
        @(negedge clock_in);
        cmp("idle_to_tx", 16'(HSC_TX), 16'(st));
        @(posedge clock_in);
        wr(ADDR_HD_DETECT, 16'h0100);
        txs <= 1'b1; // talk ends the parked hold
        rel();
        txs <= 1'b0;
        leave(HSC_TX, n);
        repeat (4) @(negedge clock_in);
        cmp("idle_stays", 16'(HSC_IDLE), 16'(st));
        // howl held, freed, then default drop
        @(posedge clock_in);
        wr(ADDR_HD_DETECT, 16'h0080);
        rdy <= 1'b1;
        rel();
        repeat (3) @(posedge clock_in);
        howl <= 1'b1;
        @(posedge clock_in);
        howl <= 1'b0;
        repeat (20) @(posedge clock_in);
        @(negedge clock_in);
        cmp("full_held", 16'h0000, 16'(full));
        @(posedge clock_in);
        wr(ADDR_HD_DETECT, 16'h0000);
        rel();
        repeat (3) @(negedge clock_in);
        cmp("full_freed", 16'h0001, 16'(full));
        @(posedge clock_in);
        howl <= 1'b1;
        @(posedge clock_in);
        howl <= 1'b0;
        @(negedge clock_in);
        cmp("howl_drop", 16'h0000, 16'(full));
        repeat (2) @(negedge clock_in);
        cmp("howl_return", 16'h0001, 16'(full));
        @(posedge clock_in);
        rd(ADDR_STATUS, 16'h2000);
        pch <= 1'b1;
        rel();
        pch <= 1'b0;
        // low sensitivity, full dt depth, tx slow, rx normal
        wr(ADDR_SUPPRESS, 16'h3F00);
        wr(ADDR_HD_DETECT, 16'h0020);
        rel();
        pch <= 1'b1;
        dtk <= 1'b1;
        @(posedge clock_in);
        pch <= 1'b0;
        @(negedge clock_in);
        cmp("path_low_full", 16'h0001, 16'(full));
        repeat (600) @(posedge clock_in);
        @(negedge clock_in);
        cmp("tx_dt_attack", 16'h0001, 16'(att.tx_dt_qdb < 8'h54));
        repeat (100) @(negedge clock_in);
        cmp("tx_dt_full", 16'h0054, 16'(att.tx_dt_qdb));
        cmp("rx_dt_full", 16'h0024, 16'(att.rx_dt_qdb));
        @(posedge clock_in);
        dtk <= 1'b0;
        repeat (1700) @(negedge clock_in);
        cmp("rx_dt_normal", 16'h0000, 16'(att.rx_dt_qdb));
        cmp("tx_dt_slow", 16'h0001, 16'(att.tx_dt_qdb > 8'h46));
        repeat (14400) @(negedge clock_in);
        cmp("tx_dt_gone", 16'h0000, 16'(att.tx_dt_qdb));
        give_verdict();
    end
endmodule
